// ---- hw/sdrc_serial_dac_ctrl.sv ----
// Control logic of a serially loaded multi-channel converter with offset sub-converters.
// Assumes all pins are asynchronous to clk_i and the link clock is far slower than clk_i.
// Contract
// - Frame low: shift serial_in on each serial_clock fall, MSB first.
// - Mode 00 writes the global control register, address ignored.
// - Mode 01 writes the addressed channel's control register only.
// - mode_sel_hi set routes the word to channel data, mode_sel_lo ignored.
// - Top bit picks main (0) or sub (1) data register.
// - Main data holds 10 bits, sub 8 bits; two low bits dropped.
// - Three address bits follow the mode bits; low 10 bits are data.
// - Octal uses three address bits, quad ignores the top one.
// - load_outputs_n falling loads every output register from its data register.
// - hw_clear_n low clears main and sub data and output registers.
// - Software clears touch main converter registers only.
// - power_down_n low powers everything down, register contents kept.
// - Coding select: 0 two's complement, 1 offset binary, for all channels.
// - Global standby one puts every channel in standby.
// - Global clear one clears all main data and output registers.
// - Channel standby low puts only that channel in standby.
// - Channel clear clears only that channel's main converter.
// - Channel clear changes take effect only on a load_outputs_n pulse.
// - Two-bit reference select drives the channel reference multiplexer.
// - Sub data uses the same coding as the main converters.
// - Reset: power up bits, standby set, channel clear set, reference 00.
`timescale 1ns/1ps
module sdrc_serial_dac_ctrl #(
	parameter int ADDR_W = 3,
	parameter int NCH = 1 << ADDR_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Serial link pins
	input wire logic frame_sync_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_in_i,
	// Strobe pins
	input wire logic load_outputs_n_i,
	input wire logic hw_clear_n_i,
	// Converter controls
	output sdrc_pkg::sdrc_chan_out_s [NCH-1:0] chan_o,
	output logic power_down_n_o,
	output logic global_standby_o,
	output logic coding_select_o
);
	logic [sdrc_pkg::SY_W-1:0] sync1_reg;
	logic [sdrc_pkg::SY_W-1:0] sync2_reg;
	logic [sdrc_pkg::SY_W-1:0] sync3_reg;
	logic [sdrc_pkg::WORD_W-1:0] shift_reg;
	logic [sdrc_pkg::WORD_W-1:0] shift_next;
	logic [sdrc_pkg::CNT_W-1:0] bit_cnt_reg;
	logic [sdrc_pkg::CNT_W-1:0] bit_cnt_next;
	logic pd_n_reg, pd_n_next;
	logic global_standby_reg, global_standby_next;
	logic coding_reg, coding_next;
	logic global_clear_reg, global_clear_next;
	sdrc_pkg::sdrc_chan_cfg_s cfg_reg [NCH];
	sdrc_pkg::sdrc_chan_cfg_s cfg_next [NCH];
	logic [sdrc_pkg::MAIN_W-1:0] dmain_reg [NCH];
	logic [sdrc_pkg::MAIN_W-1:0] dmain_next [NCH];
	logic [sdrc_pkg::SUB_W-1:0] dsub_reg [NCH];
	logic [sdrc_pkg::SUB_W-1:0] dsub_next [NCH];
	logic [NCH-1:0] clr_act_reg, clr_act_next;
	sdrc_pkg::sdrc_chan_out_s [NCH-1:0] out_reg, out_next;

	// Edges are found on the second and third stages, never on the first.
	wire sclk_fall = sync3_reg[sdrc_pkg::SY_SCLK] && !sync2_reg[sdrc_pkg::SY_SCLK];
	wire load_outputs_n_fall = sync3_reg[sdrc_pkg::SY_LOAD_OUTPUTS_N] && !sync2_reg[sdrc_pkg::SY_LOAD_OUTPUTS_N];
	wire frame_act = !sync2_reg[sdrc_pkg::SY_FS];
	wire sin_s = sync2_reg[sdrc_pkg::SY_SIN];
	wire hw_clr = !sync2_reg[sdrc_pkg::SY_CLR];
	// Bits past the sixteenth in one frame are dropped, not shifted.
	wire shift_en = sclk_fall && frame_act && (bit_cnt_reg != sdrc_pkg::DONE_CNT);
	wire commit = shift_en && (bit_cnt_reg == sdrc_pkg::LAST_BIT);
	wire [sdrc_pkg::WORD_W-1:0] word = {shift_reg[sdrc_pkg::WORD_W-2:0], sin_s};
	wire md1 = word[sdrc_pkg::B_MD1];
	wire md0 = word[sdrc_pkg::B_MD0];
	wire wr_sys = commit && !md1 && !md0;
	wire wr_chan = commit && !md1 && md0;
	wire wr_data = commit && md1;
	wire wr_main = wr_data && !word[sdrc_pkg::B_MAIN_SUB];
	wire wr_sub = wr_data && word[sdrc_pkg::B_MAIN_SUB];
	// The quad build simply takes fewer address bits, so the top one is ignored.
	wire [ADDR_W-1:0] idx = word[sdrc_pkg::B_ADDR_LO +: ADDR_W];
	wire [sdrc_pkg::MAIN_W-1:0] main_val = word[sdrc_pkg::MAIN_W-1:0];
	wire [sdrc_pkg::SUB_W-1:0] sub_val = word[sdrc_pkg::B_SUB_LO +: sdrc_pkg::SUB_W];
	wire [sdrc_pkg::MAIN_W-1:0] main_clr = sdrc_pkg::main_clear(coding_reg);
	wire [sdrc_pkg::SUB_W-1:0] sub_clr = sdrc_pkg::sub_zero(coding_reg);

	assign shift_next = shift_en ? word : shift_reg;
	assign bit_cnt_next = !frame_act ? '0 : (shift_en ? bit_cnt_reg + 5'h01 : bit_cnt_reg);

	always_comb begin
		pd_n_next = pd_n_reg;
		global_standby_next = global_standby_reg;
		coding_next = coding_reg;
		global_clear_next = global_clear_reg;
		if (wr_sys) begin
			pd_n_next = word[sdrc_pkg::B_PD];
			coding_next = word[sdrc_pkg::B_CODING];
			global_standby_next = word[sdrc_pkg::B_GLOBAL_STANDBY];
			global_clear_next = word[sdrc_pkg::B_GLOBAL_CLEAR];
		end
	end

	always_comb begin
		for (int ch = 0; ch < NCH; ch++) begin
			cfg_next[ch] = cfg_reg[ch];
			dmain_next[ch] = dmain_reg[ch];
			dsub_next[ch] = dsub_reg[ch];
			clr_act_next[ch] = clr_act_reg[ch];
			out_next[ch] = out_reg[ch];
			if (wr_chan && idx == ADDR_W'(ch)) begin
				cfg_next[ch].ref_sel = word[sdrc_pkg::B_MX_LO +: 2];
				cfg_next[ch].standby_n = word[sdrc_pkg::B_CHANNEL_STANDBY_N];
				cfg_next[ch].clear = word[sdrc_pkg::B_CLR];
			end
			if (wr_main && idx == ADDR_W'(ch)) begin
				dmain_next[ch] = main_val;
			end
			if (wr_sub && idx == ADDR_W'(ch)) begin
				dsub_next[ch] = sub_val;
			end
			if (load_outputs_n_fall) begin
				out_next[ch].main = dmain_reg[ch];
				out_next[ch].sub = dsub_reg[ch];
				clr_act_next[ch] = cfg_reg[ch].clear;
			end
			// Software clears hold while set and leave the sub converter alone.
			if (global_clear_reg || clr_act_next[ch]) begin
				dmain_next[ch] = main_clr;
				out_next[ch].main = main_clr;
			end
			if (hw_clr) begin
				dmain_next[ch] = main_clr;
				out_next[ch].main = main_clr;
				dsub_next[ch] = sub_clr;
				out_next[ch].sub = sub_clr;
			end
			out_next[ch].ref_sel = cfg_next[ch].ref_sel;
			out_next[ch].active = pd_n_next && !global_standby_next && cfg_next[ch].standby_n;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			sync3_reg <= '1;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
		end else begin
			sync1_reg <= {hw_clear_n_i, load_outputs_n_i, serial_in_i, frame_sync_n_i,
				serial_clock_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_n_reg <= sdrc_pkg::PD_RST;
			global_standby_reg <= sdrc_pkg::GLOBAL_STANDBY_RST;
			coding_reg <= sdrc_pkg::CODING_RST;
			global_clear_reg <= sdrc_pkg::GLOBAL_CLEAR_RST;
		end else begin
			pd_n_reg <= pd_n_next;
			global_standby_reg <= global_standby_next;
			coding_reg <= coding_next;
			global_clear_reg <= global_clear_next;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int ch = 0; ch < NCH; ch++) begin
				cfg_reg[ch] <= '{sdrc_pkg::REF_RST, sdrc_pkg::CHANNEL_STANDBY_N_RST, sdrc_pkg::CLR_RST};
				dmain_reg[ch] <= sdrc_pkg::MAIN_CLR_OB;
				dsub_reg[ch] <= sdrc_pkg::SUB_MID_OB;
			end
			clr_act_reg <= '1;
			out_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			dmain_reg <= dmain_next;
			dsub_reg <= dsub_next;
			clr_act_reg <= clr_act_next;
			out_reg <= out_next;
		end
	end

	assign chan_o = out_reg;
	assign power_down_n_o = pd_n_reg;
	assign global_standby_o = global_standby_reg;
	assign coding_select_o = coding_reg;

	// Checks. Channel 0 and 1 stand in for all channels.
	chk_shift_msb_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		shift_en |=> shift_reg[0] == $past(sin_s) && shift_reg[15:1] == $past(shift_reg[14:0]))
		else $error("Serial bit not shifted in at the link clock fall.");
	chk_commit_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		commit |-> frame_act && sclk_fall && bit_cnt_reg == sdrc_pkg::LAST_BIT ##1
		bit_cnt_reg == sdrc_pkg::DONE_CNT)
		else $error("Word committed at the wrong bit count.");
	chk_sys_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_sys |=> global_standby_reg == $past(word[sdrc_pkg::B_GLOBAL_STANDBY])
		&& coding_reg == $past(word[sdrc_pkg::B_CODING]))
		else $error("Global control word not stored.");
	chk_chan_ctrl: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		commit && !md1 && md0 && idx != '0 |=> $stable(cfg_reg[0]))
		else $error("Channel control written for an unaddressed channel.");
	chk_main_route: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_main && idx == '0 && !hw_clr && !global_clear_reg && !clr_act_next[0]
		|=> dmain_reg[0] == $past(main_val))
		else $error("Main data word not routed to its register.");
	chk_sub_route: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_sub && idx == '0 && !hw_clr |=> dsub_reg[0] == $past(word[9:2]) ##1 $stable(dsub_reg[0])
		|| $past(hw_clr) || $past(wr_sub))
		else $error("Sub data word not stored from bits nine to two.");
	chk_load_outputs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		load_outputs_n_fall && !hw_clr && !global_clear_reg && !cfg_reg[1].clear
		|=> out_reg[1].main == $past(dmain_reg[1]) && out_reg[1].sub == $past(dsub_reg[1]))
		else $error("Output registers not loaded on the load strobe.");
	chk_hw_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		hw_clr |=> out_reg[0].sub == sdrc_pkg::sub_zero($past(coding_reg))
		&& dmain_reg[0] == sdrc_pkg::main_clear($past(coding_reg)))
		else $error("Hardware clear did not clear main and sub.");
	chk_sys_clear_sub: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		global_clear_reg && !hw_clr && !wr_sub && !load_outputs_n_fall |=> $stable(out_reg[1].sub)
		&& $stable(dsub_reg[1]))
		else $error("Software clear disturbed a sub converter.");
	chk_chan_standby: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!cfg_next[0].standby_n |=> !out_reg[0].active)
		else $error("Channel standby did not stop the channel.");
	chk_clr_on_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!load_outputs_n_fall |=> clr_act_reg[0] == $past(clr_act_reg[0]))
		else $error("Channel clear changed without a load strobe.");
endmodule // sdrc_serial_dac_ctrl

// ---- hw/sdrc_pkg.sv ----
// Constants, field layout and carrier types for the serial converter control block.
// Assumes a single 50 MHz system clock; every pin is sampled on that clock.
package sdrc_pkg;
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam int MAIN_W = 10;
	localparam int SUB_W = 8;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
	localparam logic [CNT_W-1:0] DONE_CNT = 5'h10;
	// Positions within the received 16-bit word.
	localparam int B_MAIN_SUB = 15;
	localparam int B_MD0 = 14;
	localparam int B_MD1 = 13;
	localparam int B_ADDR_LO = 10;
	localparam int B_MX_LO = 8;
	localparam int B_CODING = 6;
	localparam int B_PD = 5;
	localparam int B_GLOBAL_STANDBY = 4;
	localparam int B_GLOBAL_CLEAR = 3;
	localparam int B_CHANNEL_STANDBY_N = 4;
	localparam int B_CLR = 3;
	localparam int B_SUB_LO = 2;
	// Reset values.
	localparam logic PD_RST = 1'h1;
	localparam logic GLOBAL_STANDBY_RST = 1'h1;
	localparam logic CODING_RST = 1'h1;
	localparam logic GLOBAL_CLEAR_RST = 1'h0;
	localparam logic [1:0] REF_RST = 2'h0;
	localparam logic CHANNEL_STANDBY_N_RST = 1'h1;
	localparam logic CLR_RST = 1'h1;
	// Clear codes: main bottom (offset binary) or midscale (two's complement), sub zero offset.
	localparam logic [MAIN_W-1:0] MAIN_CLR_OB = 10'h000;
	localparam logic [MAIN_W-1:0] MAIN_CLR_TC = 10'h000;
	localparam logic [SUB_W-1:0] SUB_MID_OB = 8'h80;
	localparam logic [SUB_W-1:0] SUB_MID_TC = 8'h00;
	// Synchroniser lanes.
	localparam int SY_SCLK = 0;
	localparam int SY_FS = 1;
	localparam int SY_SIN = 2;
	localparam int SY_LOAD_OUTPUTS_N = 3;
	localparam int SY_CLR = 4;
	localparam int SY_W = 5;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic standby_n;
		logic clear;
	} sdrc_chan_cfg_s;

	typedef struct packed {
		logic [MAIN_W-1:0] main;
		logic [SUB_W-1:0] sub;
		logic [1:0] ref_sel;
		logic active;
	} sdrc_chan_out_s;

	function automatic logic [MAIN_W-1:0] main_clear(input logic offset_bin);
		return offset_bin ? MAIN_CLR_OB : MAIN_CLR_TC;
	endfunction

	function automatic logic [SUB_W-1:0] sub_zero(input logic offset_bin);
		return offset_bin ? SUB_MID_OB : SUB_MID_TC;
	endfunction
endpackage

// ---- dv/sdrc_host_model.sv ----
// Host side model: drives frame, link clock and serial data pins.
// Assumes the caller starts each word just after a clk_i rising edge.
`timescale 1ns/1ps
module sdrc_host_model (
	// Clock
	input wire logic clk_i,
	// Serial link pins
	output logic frame_sync_n_o,
	output logic serial_clock_o,
	output logic serial_in_o
);
	initial begin
		frame_sync_n_o = 1'b1;
		serial_clock_o = 1'b1;
		serial_in_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	// A count below 16 makes a short frame that the device must drop.
	task automatic send(input logic [15:0] w, input int nbits);
		frame_sync_n_o = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			serial_in_o = w[i];
			tick(4);
			serial_clock_o = 1'b0;
			tick(4);
			serial_clock_o = 1'b1;
		end
		tick(4);
		frame_sync_n_o = 1'b1;
		// The line is released, so it must not keep showing the last bit.
		serial_in_o = ~serial_in_o;
		tick(6);
	endtask
endmodule // sdrc_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the serial converter control block.
// Assumes the host model in its own file and the octal build.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic ld_n = 1'b1;
	logic hc_n = 1'b1;
	logic fs_n, sclk, sin, pd_n, g_channel_standby_n, coding;
	sdrc_pkg::sdrc_chan_out_s [7:0] chan_o;
	sdrc_pkg::sdrc_chan_out_s [7:0] exp_ch;
	logic [2:0] exp_sys;
	logic [9:0] md [8];
	logic [7:0] sd [8];
	logic [15:0] w;
	logic [15:0] lfsr = 16'h0001;
	logic [26:0] e;
	logic [26:0] notes [$];
	event ev;
	int miscompares = 0;
	int checked = 0;
	always #10 clk_i = ~clk_i;
	sdrc_host_model host (.clk_i(clk_i), .frame_sync_n_o(fs_n), .serial_clock_o(sclk),
		.serial_in_o(sin));
	sdrc_serial_dac_ctrl #(.ADDR_W(3)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.frame_sync_n_i(fs_n), .serial_clock_i(sclk), .serial_in_i(sin),
		.load_outputs_n_i(ld_n), .hw_clear_n_i(hc_n), .chan_o(chan_o),
		.power_down_n_o(pd_n), .global_standby_o(g_channel_standby_n), .coding_select_o(coding));
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic chk(input int ch, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR chan%0d expected %h seen %h", ch, exp, seen);
		end
	endtask
	task automatic check_all(input string name);
		for (int i = 0; i < 8; i++) notes.push_back({3'(i), exp_sys, exp_ch[i]});
		->ev;
		#1;
		$display("test %s done", name);
	endtask
	task automatic set_act(input logic a);
		for (int i = 0; i < 8; i++) exp_ch[i].active = a;
	endtask
	task automatic load();
		ld_n = 1'b0;
		tick(4);
		ld_n = 1'b1;
		tick(4);
	endtask
	always begin
		@(ev);
		while (notes.size() > 0) begin
			e = notes.pop_front();
			chk(int'(e[26:24]), {pd_n, g_channel_standby_n, coding, chan_o[e[26:24]]}, e[23:0]);
		end
	end
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end
	initial begin
		tick(10);
		arst_n_i = 1'b1;
		tick(4);
		exp_sys = 3'h7;
		exp_ch = '0;
		check_all("reset");
		host.send(16'h1C60, 16);
		exp_sys = 3'h5;
		set_act(1'b1);
		check_all("system");
		for (int c = 0; c < 8; c++) begin
			host.send(16'h4010 | 16'(c << 10) | 16'((c % 4) << 8), 16);
			exp_ch[c].ref_sel = 2'(c % 4);
		end
		check_all("channel");
		// The pending clear from reset holds main data cleared, so it is released before data.
		load();
		for (int c = 0; c < 8; c++) exp_ch[c].sub = 8'h80;
		check_all("clear released");
		for (int c = 0; c < 8; c++) begin
			w = rnd();
			w[15] = 1'b0;
			w[13] = 1'b1;
			w[12:10] = 3'(c);
			md[c] = w[9:0];
			host.send(w, 16);
			w = rnd();
			w[15] = 1'b1;
			w[13] = 1'b1;
			w[12:10] = 3'(c);
			sd[c] = w[9:2];
			host.send(w, 16);
		end
		check_all("data held");
		load();
		for (int c = 0; c < 8; c++) begin
			exp_ch[c].main = md[c];
			exp_ch[c].sub = sd[c];
		end
		check_all("load");
		host.send(16'h4818, 16);
		exp_ch[2].ref_sel = 2'h0;
		check_all("chan clear held");
		load();
		exp_ch[2].main = 10'h000;
		check_all("chan clear");
		host.send(16'h0068, 16);
		for (int c = 0; c < 8; c++) exp_ch[c].main = 10'h000;
		check_all("global clear");
		host.send(16'h0060, 16);
		host.send(16'h23FF, 16);
		host.send(16'h2555, 15);
		load();
		exp_ch[0].main = 10'h3FF;
		check_all("short frame");
		host.send(16'h4400, 16);
		exp_ch[1].active = 1'b0;
		exp_ch[1].ref_sel = 2'h0;
		check_all("chan standby");
		host.send(16'h0070, 16);
		exp_sys = 3'h7;
		set_act(1'b0);
		check_all("global standby");
		host.send(16'h0040, 16);
		exp_sys = 3'h1;
		check_all("power down");
		host.send(16'h0020, 16);
		exp_sys = 3'h4;
		set_act(1'b1);
		exp_ch[1].active = 1'b0;
		hc_n = 1'b0;
		tick(6);
		for (int c = 0; c < 8; c++) exp_ch[c].main = 10'h000;
		for (int c = 0; c < 8; c++) exp_ch[c].sub = 8'h00;
		check_all("hw clear tc");
		hc_n = 1'b1;
		host.send(16'h0060, 16);
		exp_sys = 3'h5;
		hc_n = 1'b0;
		tick(6);
		for (int c = 0; c < 8; c++) exp_ch[c].sub = 8'h80;
		check_all("hw clear ob");
		hc_n = 1'b1;
		tick(4);
		end_of_test();
	end
endmodule // tb_top
